// *** bench/seecar_checker.sv ***
// Checker for the current-address read slave
`timescale 1ns/100ps

module seecar_checker
#(
  parameter int ADDR_W = 9
)
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              scl,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              sda_oe,
  input wire logic              write_busy,
  input wire logic              mem_we,
  input wire logic [ADDR_W-1:0] mem_waddr,
  input wire logic [7:0]        mem_wdata,
  input wire logic              standby,
  input wire logic [ADDR_W-1:0] addr_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_write_count: assert property (mem_we |=> addr_count == ADDR_W'($past(mem_waddr) + 1'b1))
    else $error("count not past write");
  chk_idle_hold: assert property (standby && $past(standby) && !$past(mem_we) |-> $stable(addr_count))
    else $error("count moved idle");
  chk_open_drain: assert property (!sda_o)
    else $error("data pin driven high");
  chk_drive_active: assert property (sda_oe |-> !standby)
    else $error("drive in standby");
  chk_stop_idle: assert property ($rose(standby) |-> scl && sda_i && !sda_oe)
    else $error("standby without stop");
  // Sync lag means the pin has been low for two samples before any output move
  chk_oe_edge: assert property ($changed(sda_oe) |-> !scl && !$past(scl, 2))
    else $error("output moved off falling edge");
  chk_read_step: assert property ($changed(addr_count) && !$past(mem_we) |-> addr_count == $past(addr_count) + 1'b1)
    else $error("read step not one");
  chk_step_edge: assert property ($changed(addr_count) && !$past(mem_we) |-> !scl && !standby)
    else $error("step outside read");
endmodule : seecar_checker

bind seecar_top seecar_checker #(.ADDR_W(ADDR_W)) seecar_checker_inst (.clk, .rst_b, .scl, .sda_i, .sda_o,
  .sda_oe, .write_busy, .mem_we, .mem_waddr, .mem_wdata, .standby, .addr_count);

// *** bench/seecar_master.sv ***
// Bus master model running one framed transfer
`timescale 1ns/100ps

module seecar_master
(
  input  wire logic clk,
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data moves mid-low, sampled mid-high
  task automatic slot(input logic b, output logic s);
    #16 sda_pull = ~b;
    #16 scl = 1'b1;
    #16 s = sda;
    #16 scl = 1'b0;
  endtask : slot

  // Start, address byte, one byte in, high ack, stop
  task automatic frame(input logic [7:0] a, output logic ack, output logic [7:0] d);
    logic s;
    // Fractional offset keeps every pin move of the frame clear of both clock edges
    @(posedge clk);
    #1.2;
    sda_pull = 1'b1;
    #16 scl = 1'b0;
    for (int i = 7; i >= 0; i--)
      slot(a[i], s);
    slot(1'b1, ack);
    for (int i = 7; i >= 0; i--)
      slot(1'b1, d[i]);
    slot(1'b1, s);
    #16 sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #32;
  endtask : frame
endmodule : seecar_master

// *** bench/tb.sv ***
// Testbench for the current-address read slave
`timescale 1ns/100ps

module tb;
  int         fail_count = 0;
  int         num_checks = 0;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       scl, sda_pull, sda_o, sda_oe, standby;
  logic       write_busy = 1'b0;
  logic       mem_we = 1'b0;
  logic [8:0] mem_waddr = 9'h0;
  logic [7:0] mem_wdata = 8'h0;
  logic [8:0] addr_count;
  // Open drain with pull-up
  wire        sda = ~(sda_pull | sda_oe);

  seecar_top seecar_top_inst (.clk, .rst_b, .scl, .sda_i(sda), .sda_o, .sda_oe, .write_busy, .mem_we,
    .mem_waddr, .mem_wdata, .standby, .addr_count);
  seecar_master seecar_master_inst (.clk, .scl, .sda_pull, .sda);

  always #2.5 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : check

  task automatic idle_wait();
    for (int i = 0; i < 40 && standby !== 1'b1; i++)
      @(posedge clk);
    check(16'(standby), 16'h1);
    if (standby !== 1'b1)
      end_of_test();
  endtask : idle_wait

  task automatic mem_write(input logic [8:0] a, input logic [7:0] v);
    @(posedge clk);
    mem_we <= 1'b1;
    mem_waddr <= a;
    mem_wdata <= v;
    @(posedge clk);
    mem_we <= 1'b0;
    @(posedge clk);
    // Sum is formed at the counter's own width so a write at the top location wraps to zero
    #1 check(16'(addr_count), 16'(9'(a + 9'h1)));
  endtask : mem_write

  // Last write at the top location wraps the counter to zero
  task automatic t_preload();
    mem_write(9'h000, 8'h3c);
    mem_write(9'h001, 8'hc3);
    mem_write(9'h1ff, 8'ha5);
    $display("preload done");
  endtask : t_preload

  task automatic t_reads();
    logic       ack;
    logic [7:0] d;
    logic [7:0] exp [2] = '{8'h3c, 8'hc3};
    for (int i = 0; i < 2; i++)
    begin
      seecar_master_inst.frame(8'ha1, ack, d);
      idle_wait();
      check(16'(ack), 16'h0);
      check(16'(d), 16'(exp[i]));
      check(16'(addr_count), 16'(i + 1));
    end
    $display("reads done");
  endtask : t_reads

  // Busy read, idle write probe, foreign address
  task automatic t_refuse();
    logic       ack;
    logic [7:0] d;
    logic [7:0] ab [3] = '{8'ha1, 8'ha0, 8'ha3};
    logic [2:0] busy = 3'b001;
    logic [2:0] nak = 3'b101;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      write_busy <= busy[i];
      seecar_master_inst.frame(ab[i], ack, d);
      idle_wait();
      check(16'(ack), 16'(nak[i]));
      check(16'(d), 16'h00ff);
      check(16'(addr_count), 16'h2);
    end
    $display("refusals done");
  endtask : t_refuse

  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'(addr_count), 16'h0);
    t_preload();
    t_reads();
    t_refuse();
    end_of_test();
  end
endmodule : tb

// *** hw/seecar_pkg.sv ***
// Types shared by the serial EEPROM current-address read slave
package seecar_pkg;

  typedef enum logic [2:0] {
    SEECAR_IDLE  = 3'b000,
    SEECAR_ADDR  = 3'b001,
    SEECAR_ACK   = 3'b010,
    SEECAR_TX    = 3'b011,
    SEECAR_MACK  = 3'b100,
    SEECAR_WSTOP = 3'b101
  } seecar_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } seecar_line_s;

endpackage : seecar_pkg

// *** hw/seecar_regs.svh ***
// Constants for the serial EEPROM current-address read slave
// Operation
// - After any read or write of location n the internal address counter holds n plus one.
// - A current-address read returns the byte at the counter location with no word address sent.
// - After a low acknowledge of the read address byte the device drives one data byte, most significant bit first.
// - A high acknowledge from the master followed by a stop ends the read, and the device releases the data line and goes to standby.
// - Data is sampled on the rising clock edge and the device changes its output on the falling edge.
// - While an internal write cycle runs the device answers its address with a high acknowledge, and with a low one once it ends.
`ifndef SEECAR_REGS_SVH
`define SEECAR_REGS_SVH

`define SEECAR_BYTE_BITS   4'h8
`define SEECAR_BIT_ZERO    4'h0
`define SEECAR_BIT_ONE     4'h1
`define SEECAR_RW_POS      0
`define SEECAR_MSB_POS     7
`define SEECAR_DEV_ADDR    7'h50
`define SEECAR_MAX_ADDR_W  16

`endif

// *** hw/seecar_top.sv ***
// Two-wire serial EEPROM slave answering the current-address read
`timescale 1ns/100ps
`include "seecar_regs.svh"

module seecar_top
  import seecar_pkg::*;
#(
  parameter int         ADDR_W   = 9,
  parameter logic [6:0] DEV_ADDR = `SEECAR_DEV_ADDR
)
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              scl,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic              write_busy,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_waddr,
  input  wire logic [7:0]        mem_wdata,
  output logic                   standby,
  output logic [ADDR_W-1:0]      addr_count
);

  localparam int DEPTH = 1 << ADDR_W;

  if (ADDR_W < 1 || ADDR_W > `SEECAR_MAX_ADDR_W)
  begin : g_chk_addr_w
    $error("seecar_top: ADDR_W out of range");
  end

  seecar_line_s              sync1_q;
  seecar_line_s              sync2_q;
  seecar_line_s              prev_q;
  seecar_state_e             state_q;
  logic [3:0]                bitcnt_q;
  logic [7:0]                shreg_q;
  logic                      rw_q;
  logic                      oe_q;
  logic                      out_q;
  logic                      stby_q;
  logic [ADDR_W-1:0]         cnt_q;
  logic [7:0]                mem [DEPTH];

  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_seen;
  logic                      stop_seen;
  logic                      addr_match;
  logic                      load_byte;
  logic [7:0]                rd_byte;

  function automatic logic [ADDR_W-1:0] seecar_next(input logic [ADDR_W-1:0] a);
    seecar_next = a + {{(ADDR_W-1){1'b0}}, 1'b1};
  endfunction : seecar_next

  // Both pins cross two flops before anything looks at them
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= '{scl: 1'b1, sda: 1'b1};
      sync2_q <= '{scl: 1'b1, sda: 1'b1};
      prev_q  <= '{scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      sync1_q <= '{scl: scl, sda: sda_i};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign scl_rise   = sync2_q.scl & ~prev_q.scl;
  assign scl_fall   = ~sync2_q.scl & prev_q.scl;
  // Clock held high while data moves marks start or stop
  assign start_seen = sync2_q.scl & prev_q.scl & prev_q.sda & ~sync2_q.sda;
  assign stop_seen  = sync2_q.scl & prev_q.scl & ~prev_q.sda & sync2_q.sda;

  // Busy write cycle means no acknowledge, whatever the direction
  assign addr_match = (shreg_q[7:1] == DEV_ADDR) & ~write_busy;

  assign rd_byte    = mem[cnt_q];

  // A byte is fetched on the falling edge that closes an acknowledge
  assign load_byte  = scl_fall & ((state_q == SEECAR_ACK && rw_q) || (state_q == SEECAR_MACK && !rw_q));

  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // Counter follows the last location touched, read or write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
    end
    else if (mem_we)
    begin
      cnt_q <= seecar_next(mem_waddr);
    end
    else if (load_byte)
    begin
      cnt_q <= seecar_next(cnt_q);
    end
  end

  // Protocol sequencing; rw_q is reused in MACK to hold the master acknowledge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q  <= SEECAR_IDLE;
      bitcnt_q <= `SEECAR_BIT_ZERO;
      shreg_q  <= 8'h00;
      rw_q     <= 1'b0;
      oe_q     <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_q <= SEECAR_IDLE;
      oe_q    <= 1'b0;
    end
    else if (start_seen)
    begin
      state_q  <= SEECAR_ADDR;
      bitcnt_q <= `SEECAR_BIT_ZERO;
      oe_q     <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        SEECAR_IDLE:
        begin
          oe_q <= 1'b0;
        end
        SEECAR_ADDR:
        begin
          if (scl_rise && bitcnt_q != `SEECAR_BYTE_BITS)
          begin
            shreg_q  <= {shreg_q[6:0], sync2_q.sda};
            bitcnt_q <= bitcnt_q + `SEECAR_BIT_ONE;
          end
          else if (scl_fall && bitcnt_q == `SEECAR_BYTE_BITS)
          begin
            rw_q <= shreg_q[`SEECAR_RW_POS];
            if (addr_match)
            begin
              oe_q    <= 1'b1;
              state_q <= SEECAR_ACK;
            end
            else
            begin
              state_q <= SEECAR_WSTOP;
            end
          end
        end
        SEECAR_ACK:
        begin
          if (scl_fall)
          begin
            bitcnt_q <= `SEECAR_BIT_ZERO;
            if (rw_q)
            begin
              // Drive a 0 by enabling, a 1 by releasing the line
              oe_q    <= ~rd_byte[`SEECAR_MSB_POS];
              shreg_q <= {rd_byte[6:0], 1'b0};
              state_q <= SEECAR_TX;
            end
            else
            begin
              // Writes are served elsewhere; only polling is answered here
              oe_q    <= 1'b0;
              state_q <= SEECAR_WSTOP;
            end
          end
        end
        SEECAR_TX:
        begin
          if (scl_rise)
          begin
            bitcnt_q <= bitcnt_q + `SEECAR_BIT_ONE;
          end
          else if (scl_fall)
          begin
            if (bitcnt_q == `SEECAR_BYTE_BITS)
            begin
              oe_q    <= 1'b0;
              state_q <= SEECAR_MACK;
            end
            else
            begin
              oe_q    <= ~shreg_q[`SEECAR_MSB_POS];
              shreg_q <= {shreg_q[6:0], 1'b0};
            end
          end
        end
        SEECAR_MACK:
        begin
          if (scl_rise)
          begin
            rw_q <= sync2_q.sda;
          end
          else if (scl_fall)
          begin
            bitcnt_q <= `SEECAR_BIT_ZERO;
            if (!rw_q)
            begin
              // Low acknowledge asks for the next location
              oe_q    <= ~rd_byte[`SEECAR_MSB_POS];
              shreg_q <= {rd_byte[6:0], 1'b0};
              state_q <= SEECAR_TX;
            end
            else
            begin
              oe_q    <= 1'b0;
              state_q <= SEECAR_WSTOP;
            end
          end
        end
        SEECAR_WSTOP:
        begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Output flops; the data pin only ever pulls low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_q  <= 1'b0;
      stby_q <= 1'b1;
    end
    else
    begin
      out_q  <= 1'b0;
      stby_q <= (state_q == SEECAR_IDLE);
    end
  end

  assign sda_o      = out_q;
  assign sda_oe     = oe_q;
  assign standby    = stby_q;
  assign addr_count = cnt_q;

endmodule : seecar_top
